// ---- inc/sfb_pkg.sv ----
// Constants and types for the status flags and banked data RAM block
`default_nettype none
// What this block does
// - On subtraction carry and digit carry read as inverted borrow; set means no borrow.
// - Subtraction adds the two's complement of the second operand; flags come from it.
// - Rotate through carry loads carry with bit 7 on left, bit 0 on right.
// - Each bank offers up to 80 bytes of general RAM by banked direct addressing.
// - Sixteen bytes of common RAM are the same storage in every bank.
// - Pointer register reaches general RAM as one linear space of concatenated bank segments.
// - Flag-updating instruction aimed at the flags register keeps logic flags, drops write.
// - Watchdog-expiry and power-down flags ignore software writes; only hardware moves them.
// - Clearing the flags register clears bits 7:5, sets zero, leaves the rest.
// - Data memory is 32 banks of 128 bytes; bank select register picks the bank.
package sfb_pkg;
    // Bus register byte offsets
    localparam logic [7:0] OFS_CPU_FLAGS = 8'h00;
    localparam logic [7:0] OFS_BANK_SELECT = 8'h04;
    localparam logic [7:0] OFS_POINTER = 8'h08;
    localparam logic [7:0] OFS_DATA_WINDOW = 8'h0C;
    // Flag bit positions
    localparam int BIT_C = 0;
    localparam int BIT_NIBBLE = 1;
    localparam int BIT_Z = 2;
    localparam int BIT_POWER_DOWN = 3;
    localparam int BIT_EXPIRY = 4;
    // Values after reset
    localparam logic [7:0] FLAGS_RESET = 8'h18;
    localparam logic [4:0] BANK_RESET = 5'h00;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    // Memory layout
    localparam int NUM_BANKS = 32;
    localparam int BANK_BYTES = 128;
    localparam int GEN_BYTES = 80;
    localparam int COMMON_BYTES = 16;
    localparam logic [6:0] GEN_BASE = 7'h20;
    localparam logic [6:0] COMMON_BASE = 7'h70;
    localparam logic [15:0] LINEAR_BASE = 16'h2000;
    localparam int RAM_DEPTH = NUM_BANKS * GEN_BYTES + COMMON_BYTES;
    localparam int RAM_AW = 12;
    localparam logic [11:0] GEN_TOTAL = 12'(NUM_BANKS * GEN_BYTES);
    localparam logic [11:0] GEN_BYTES_12 = 12'(GEN_BYTES);
    // Operations from the core's decoder
    typedef enum logic [3:0] {
        ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR, ALU_XOR,
        ALU_CLR, ALU_MOV, ALU_ROTATE_LEFT, ALU_ROTATE_RIGHT, ALU_SWAP
    } sfb_alu_op_e;
    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE, BUS_ACT, BUS_RDWAIT, BUS_DONE
    } sfb_bus_state_e;
endpackage
`default_nettype wire

// ---- tb/sfb_core_model.sv ----
// Core decoder model that issues ALU, event and memory requests
`default_nettype none
module sfb_core_model (
    // Clock
    input wire logic clk,
    // ALU request
    output var logic aluValid,
    output var sfb_pkg::sfb_alu_op_e aluOp,
    output var logic [7:0] aluA,
    output var logic [7:0] aluB,
    output var logic aluToStatus,
    // Reset cause events
    output var logic porEvent,
    output var logic clrWdtEvent,
    output var logic sleepEvent,
    output var logic wdtTimeoutEvent,
    // Memory request
    output var logic memValid,
    output var logic memWrite,
    output var logic memIndirect,
    output var logic [6:0] memAddr,
    output var logic [7:0] memWdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {aluValid, aluToStatus, aluA, aluB} = 18'h0_0000;
        aluOp = sfb_pkg::ALU_ADD;
        {porEvent, clrWdtEvent, sleepEvent, wdtTimeoutEvent} = 4'h0;
        {memValid, memWrite, memIndirect, memAddr, memWdata} = 18'h0_0000;
    end
    // Released operands show their inverse so stale values cannot pass
    task automatic alu(input sfb_pkg::sfb_alu_op_e op, input logic [7:0] a, b, input logic ts);
        @(posedge clk);
        {aluValid, aluA, aluB, aluToStatus} <= {1'b1, a, b, ts};
        aluOp <= op;
        @(posedge clk);
        {aluValid, aluA, aluB} <= {1'b0, ~a, ~b};
    endtask
    task automatic ev(input logic [3:0] e);
        @(posedge clk);
        {porEvent, clrWdtEvent, sleepEvent, wdtTimeoutEvent} <= e;
        @(posedge clk);
        {porEvent, clrWdtEvent, sleepEvent, wdtTimeoutEvent} <= 4'h0;
    endtask
    task automatic mem(input logic w, ind, input logic [6:0] ad, input logic [7:0] wd);
        @(posedge clk);
        {memValid, memWrite, memIndirect, memAddr, memWdata} <= {1'b1, w, ind, ad, wd};
        @(posedge clk);
        {memValid, memWdata} <= {1'b0, ~wd};
    endtask
endmodule
`default_nettype wire

// ---- tb/sfb_core_sva.sv ----
// Checker for the flag logic, memory map and bus wait states of sfb_core
`default_nettype none
module sfb_core_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // ALU
    input wire logic aluValid,
    input wire sfb_pkg::sfb_alu_op_e aluOp,
    input wire logic [7:0] aluA,
    input wire logic [7:0] aluB,
    input wire logic aluToStatus,
    input wire logic [7:0] aluResult,
    // Events
    input wire logic porEvent,
    input wire logic clrWdtEvent,
    input wire logic sleepEvent,
    input wire logic wdtTimeoutEvent,
    // Memory
    input wire logic memValid,
    input wire logic memWrite,
    input wire logic memIndirect,
    input wire logic [6:0] memAddr,
    input wire logic [7:0] memRdata,
    input wire logic memRdataValid,
    // Flags
    input wire logic [7:0] cpuFlags
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Events would legally move the reset-cause bits, so they gate the flag checks
    wire anyEv = porEvent | clrWdtEvent | sleepEvent | wdtTimeoutEvent;
    wire aluPlain = aluValid & ~aluToStatus & ~anyEv;
    sequence s_sub;
        aluPlain && aluOp == sfb_pkg::ALU_SUB;
    endsequence
    sequence s_taken;
        hsel && htrans[1] && hready;
    endsequence
    property p_sub_borrow;
        s_sub |=> cpuFlags[1:0] == {$past(aluA[3:0]) >= $past(aluB[3:0]),
            $past(aluA) >= $past(aluB)};
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("Borrow flags wrong after subtract");
    property p_sub_sum;
        s_sub |=> aluResult == 8'($past(aluA) - $past(aluB));
    endproperty
    a_sub_sum: assert property (p_sub_sum)
        else $error("Subtract result wrong");
    property p_rotate;
        aluPlain && aluOp == sfb_pkg::ALU_ROTATE_LEFT |=> cpuFlags[0] == $past(aluA[7]);
    endproperty
    a_rotate: assert property (p_rotate)
        else $error("Left rotate carry wrong");
    property p_add_flags;
        aluPlain && aluOp == sfb_pkg::ALU_ADD
            |=> cpuFlags[2] == (8'($past(aluA) + $past(aluB)) == 8'h00)
            && cpuFlags[0] == ((9'($past(aluA)) + 9'($past(aluB))) > 9'h0FF);
    endproperty
    a_add_flags: assert property (p_add_flags)
        else $error("Add zero or carry wrong");
    property p_clr_status;
        aluValid && aluToStatus && aluOp == sfb_pkg::ALU_CLR && !anyEv
            |=> cpuFlags == {3'b000, $past(cpuFlags[4:3]), 1'b1, $past(cpuFlags[1:0])};
    endproperty
    a_clr_status: assert property (p_clr_status)
        else $error("Clear of flags register wrong");
    property p_cause_hold;
        !anyEv |=> cpuFlags[4:3] == $past(cpuFlags[4:3]);
    endproperty
    a_cause_hold: assert property (p_cause_hold)
        else $error("Reset cause bits moved without event");
    property p_sleep;
        sleepEvent && !porEvent && !clrWdtEvent |=> cpuFlags[4:3] == 2'b10;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("Sleep did not set cause bits");
    property p_low_zero;
        memValid && !memWrite && !memIndirect && memAddr < 7'h20
            |=> memRdataValid && memRdata == 8'h00;
    endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("Offset below general RAM not zero");
    property p_bus_wait;
        s_taken |=> !hreadyout && hresp == 1'b0;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("Bus did not wait after address phase");
endmodule
`default_nettype wire

// ---- tb/status_flags_banked_ram_bench.sv ----
// Self-checking bench for the status flags and banked RAM block
`default_nettype none
module status_flags_banked_ram_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, hsel, hwrite;
    logic [31:0] haddr, hwdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hreadyout, hresp, aluValid, aluToStatus, aluResultValid;
    wire logic porEvent, clrWdtEvent, sleepEvent, wdtTimeoutEvent;
    wire logic memValid, memWrite, memIndirect, memRdataValid;
    wire logic [31:0] hrdata;
    wire sfb_pkg::sfb_alu_op_e aluOp;
    wire logic [7:0] aluA, aluB, aluResult, memWdata, memRdata, cpuFlags;
    wire logic [6:0] memAddr;
    wire logic [4:0] bankSelect;
    wire logic [15:0] pointerValue;
    // Single slave, so its ready is the bus ready
    wire logic hready = hreadyout;
    logic [7:0] ef;
    int err_total = 0, samples_checked = 0, cyc = 0;
    sfb_core dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .aluValid(aluValid),
        .aluOp(aluOp), .aluA(aluA), .aluB(aluB), .aluToStatus(aluToStatus),
        .aluResult(aluResult), .aluResultValid(aluResultValid), .porEvent(porEvent),
        .clrWdtEvent(clrWdtEvent), .sleepEvent(sleepEvent), .wdtTimeoutEvent(wdtTimeoutEvent),
        .memValid(memValid), .memWrite(memWrite), .memIndirect(memIndirect), .memAddr(memAddr),
        .memWdata(memWdata), .memRdata(memRdata), .memRdataValid(memRdataValid),
        .cpuFlags(cpuFlags), .bankSelect(bankSelect), .pointerValue(pointerValue));
    sfb_core_model m (.clk(clk), .aluValid(aluValid), .aluOp(aluOp), .aluA(aluA), .aluB(aluB),
        .aluToStatus(aluToStatus), .porEvent(porEvent), .clrWdtEvent(clrWdtEvent),
        .sleepEvent(sleepEvent), .wdtTimeoutEvent(wdtTimeoutEvent), .memValid(memValid),
        .memWrite(memWrite), .memIndirect(memIndirect), .memAddr(memAddr), .memWdata(memWdata));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task complete_run;
        $display("Counts: %0d checked, %0d mismatched", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // A hung handshake ends the run here
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] seen, exp);
        samples_checked = samples_checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h00_0000, a, w};
        do @(posedge clk); while (hready !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, 16'h0000, d};
        do @(posedge clk); while (hready !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic alu_t(input sfb_pkg::sfb_alu_op_e op, input logic [7:0] a, b);
        logic [8:0] s;
        logic [7:0] r;
        logic c, d;
        {d, c} = ef[1:0];
        s = 9'(a) + 9'(b);
        case (op)
            sfb_pkg::ALU_ADD: {r, c, d} = {s[7:0], s[8], (a[3:0] + b[3:0]) > 15};
            sfb_pkg::ALU_SUB: {r, c, d} = {8'(a - b), a >= b, a[3:0] >= b[3:0]};
            sfb_pkg::ALU_ROTATE_LEFT: {r, c} = {a[6:0], ef[0], a[7]};
            default: {r, c} = {ef[0], a[7:1], a[0]};
        endcase
        if (op == sfb_pkg::ALU_ADD || op == sfb_pkg::ALU_SUB)
            ef[2] = (r == 8'h00);
        ef[1:0] = {d, c};
        m.alu(op, a, b, 1'b0);
        #1;
        chk({cpuFlags, aluResult}, {ef, r});
        chk(aluResultValid, 32'h0000_0001);
    endtask
    task automatic rd_mem(input logic ind, input logic [6:0] ad, input logic [7:0] exp);
        m.mem(1'b0, ind, ad, 8'h00);
        #1;
        chk({memRdataValid, memRdata}, {1'b1, exp});
    endtask
    initial begin
        {rst_n, hsel, htrans, haddr, hwrite, hwdata} = 69'h0;
        hsize = 3'h2;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({cpuFlags, bankSelect, pointerValue}, {8'h18, 5'h00, 16'h0000});
        bus(1'b0, 8'h00, 16'h0000);
        chk(rdv, 32'h0000_0018);
        ef = 8'h18;
        $display("Reset test done");
        alu_t(sfb_pkg::ALU_ADD, 8'hFF, 8'h01);
        alu_t(sfb_pkg::ALU_ADD, 8'h08, 8'h08);
        alu_t(sfb_pkg::ALU_SUB, 8'h05, 8'h05);
        alu_t(sfb_pkg::ALU_SUB, 8'h03, 8'h05);
        alu_t(sfb_pkg::ALU_SUB, 8'h10, 8'h01);
        alu_t(sfb_pkg::ALU_ROTATE_LEFT, 8'h80, 8'h00);
        alu_t(sfb_pkg::ALU_ROTATE_RIGHT, 8'h02, 8'h00);
        alu_t(sfb_pkg::ALU_ROTATE_RIGHT, 8'h01, 8'h00);
        $display("Arithmetic test done");
        bus(1'b1, 8'h00, 16'h00FF);
        bus(1'b0, 8'h00, 16'h0000);
        chk(rdv, 32'h0000_001F);
        m.ev(4'h2);
        #1 chk(cpuFlags, 8'h17);
        bus(1'b1, 8'h00, 16'h000B);
        bus(1'b0, 8'h00, 16'h0000);
        chk(rdv, 32'h0000_0013);
        m.alu(sfb_pkg::ALU_CLR, 8'h00, 8'h00, 1'b1);
        #1 chk(cpuFlags, 8'h17);
        m.alu(sfb_pkg::ALU_ADD, 8'h01, 8'h01, 1'b1);
        #1 chk(cpuFlags, 8'h10);
        m.ev(4'h1);
        #1 chk(cpuFlags, 8'h00);
        m.ev(4'h8);
        #1 chk(cpuFlags, 8'h18);
        $display("Flags register test done");
        bus(1'b1, 8'h04, 16'h0003);
        m.mem(1'b1, 1'b0, 7'h70, 8'hA5);
        bus(1'b1, 8'h04, 16'h0011);
        chk(bankSelect, 32'h0000_0011);
        rd_mem(1'b0, 7'h70, 8'hA5);
        bus(1'b1, 8'h04, 16'h0002);
        m.mem(1'b1, 1'b0, 7'h20, 8'h11);
        m.mem(1'b1, 1'b0, 7'h6F, 8'h33);
        bus(1'b1, 8'h04, 16'h0005);
        m.mem(1'b1, 1'b0, 7'h20, 8'h22);
        m.mem(1'b1, 1'b0, 7'h10, 8'hEE);
        rd_mem(1'b0, 7'h10, 8'h00);
        rd_mem(1'b0, 7'h20, 8'h22);
        bus(1'b1, 8'h04, 16'h0002);
        rd_mem(1'b0, 7'h20, 8'h11);
        rd_mem(1'b0, 7'h6F, 8'h33);
        bus(1'b1, 8'h08, 16'h20A0);
        bus(1'b0, 8'h0C, 16'h0000);
        chk(rdv, 32'h0000_0011);
        bus(1'b1, 8'h08, 16'h20EF);
        rd_mem(1'b1, 7'h00, 8'h33);
        bus(1'b1, 8'h08, 16'h2190);
        bus(1'b0, 8'h0C, 16'h0000);
        chk(rdv, 32'h0000_0022);
        bus(1'b1, 8'h08, 16'h0120);
        rd_mem(1'b1, 7'h00, 8'h11);
        bus(1'b0, 8'h08, 16'h0000);
        chk(rdv, 32'h0000_0120);
        chk(pointerValue, 32'h0000_0120);
        bus(1'b1, 8'h0C, 16'h005A);
        rd_mem(1'b0, 7'h20, 8'h5A);
        bus(1'b0, 8'h04, 16'h0000);
        chk(rdv, 32'h0000_0002);
        bus(1'b0, 8'h10, 16'h0000);
        chk(rdv, 32'h0000_0000);
        $display("Memory map test done");
        complete_run();
    end
endmodule
bind sfb_core sfb_core_sva chk_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .aluValid(aluValid), .aluOp(aluOp),
    .aluA(aluA), .aluB(aluB), .aluToStatus(aluToStatus), .aluResult(aluResult),
    .porEvent(porEvent), .clrWdtEvent(clrWdtEvent), .sleepEvent(sleepEvent),
    .wdtTimeoutEvent(wdtTimeoutEvent), .memValid(memValid), .memWrite(memWrite),
    .memIndirect(memIndirect), .memAddr(memAddr), .memRdata(memRdata),
    .memRdataValid(memRdataValid), .cpuFlags(cpuFlags));
`default_nettype wire

// ---- verilog/sfb_core.sv ----
// Status flags, bank select, pointer and banked data RAM with AHB-Lite access
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`default_nettype none
module sfb_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // ALU request from the decoder
    input wire logic aluValid,
    input wire sfb_pkg::sfb_alu_op_e aluOp,
    input wire logic [7:0] aluA,
    input wire logic [7:0] aluB,
    input wire logic aluToStatus,
    output logic [7:0] aluResult,
    output logic aluResultValid,
    // Reset cause events from the core
    input wire logic porEvent,
    input wire logic clrWdtEvent,
    input wire logic sleepEvent,
    input wire logic wdtTimeoutEvent,
    // Core data memory port
    input wire logic memValid,
    input wire logic memWrite,
    input wire logic memIndirect,
    input wire logic [6:0] memAddr,
    input wire logic [7:0] memWdata,
    output logic [7:0] memRdata,
    output logic memRdataValid,
    // State seen by the core
    output logic [7:0] cpuFlags,
    output logic [4:0] bankSelect,
    output logic [15:0] pointerValue
);
    // Maps a bank and offset, or a pointer, to {hit, physical index}
    function automatic logic [12:0] mapBanked(input logic [4:0] bank, input logic [6:0] off);
        logic [11:0] base;
        base = 12'(bank) * sfb_pkg::GEN_BYTES_12;
        if (off >= sfb_pkg::COMMON_BASE) begin
            mapBanked = {1'b1, sfb_pkg::GEN_TOTAL + 12'(off - sfb_pkg::COMMON_BASE)};
        end else if (off >= sfb_pkg::GEN_BASE) begin
            mapBanked = {1'b1, base + 12'(off - sfb_pkg::GEN_BASE)};
        end else begin
            mapBanked = 13'h0000;
        end
    endfunction

    function automatic logic [12:0] mapPointer(input logic [15:0] ptr);
        logic [15:0] lin;
        lin = ptr - sfb_pkg::LINEAR_BASE;
        if (ptr >= sfb_pkg::LINEAR_BASE && lin < 16'(sfb_pkg::GEN_TOTAL)) begin
            mapPointer = {1'b1, lin[11:0]};
        end else if (ptr[15:12] == 4'h0) begin
            mapPointer = mapBanked(ptr[11:7], ptr[6:0]);
        end else begin
            mapPointer = 13'h0000;
        end
    endfunction

    logic [7:0] flags_reg, flags_next;
    logic [4:0] bank_reg;
    logic [15:0] ptr_reg;
    sfb_pkg::sfb_bus_state_e bus_reg, bus_next;
    logic [7:0] addr_reg;
    logic write_reg;
    logic [31:0] rdata_reg;
    logic [7:0] aluRes_reg;
    logic aluVal_reg;
    logic memVal_reg;
    logic memHit_reg;

    // ALU arithmetic
    logic [7:0] bInv;
    logic [8:0] addSum, subSum;
    logic [4:0] addNib, subNib;
    assign bInv = ~aluB;
    assign addSum = {1'b0, aluA} + {1'b0, aluB};
    assign addNib = {1'b0, aluA[3:0]} + {1'b0, aluB[3:0]};
    assign subSum = {1'b0, aluA} + {1'b0, bInv} + 9'h001;
    assign subNib = {1'b0, aluA[3:0]} + {1'b0, bInv[3:0]} + 5'h01;

    logic [7:0] aluRes;
    logic cNew, nibNew;
    logic affZ, affNib, affC;
    always_comb begin
        aluRes = aluA;
        cNew = flags_reg[sfb_pkg::BIT_C];
        nibNew = flags_reg[sfb_pkg::BIT_NIBBLE];
        affZ = 1'b0;
        affNib = 1'b0;
        affC = 1'b0;
        case (aluOp)
            sfb_pkg::ALU_ADD: begin
                aluRes = addSum[7:0];
                nibNew = addNib[4];
                cNew = addSum[8];
                affZ = 1'b1;
                affNib = 1'b1;
                affC = 1'b1;
            end
            sfb_pkg::ALU_SUB: begin
                // Carry out of the complement sum is the inverted borrow
                aluRes = subSum[7:0];
                nibNew = subNib[4];
                cNew = subSum[8];
                affZ = 1'b1;
                affNib = 1'b1;
                affC = 1'b1;
            end
            sfb_pkg::ALU_AND: begin
                aluRes = aluA & aluB;
                affZ = 1'b1;
            end
            sfb_pkg::ALU_IOR: begin
                aluRes = aluA | aluB;
                affZ = 1'b1;
            end
            sfb_pkg::ALU_XOR: begin
                aluRes = aluA ^ aluB;
                affZ = 1'b1;
            end
            sfb_pkg::ALU_CLR: begin
                aluRes = 8'h00;
                affZ = 1'b1;
            end
            sfb_pkg::ALU_MOV: begin
                aluRes = aluA;
                affZ = 1'b1;
            end
            sfb_pkg::ALU_ROTATE_LEFT: begin
                aluRes = {aluA[6:0], flags_reg[sfb_pkg::BIT_C]};
                cNew = aluA[7];
                affC = 1'b1;
            end
            sfb_pkg::ALU_ROTATE_RIGHT: begin
                aluRes = {flags_reg[sfb_pkg::BIT_C], aluA[7:1]};
                cNew = aluA[0];
                affC = 1'b1;
            end
            sfb_pkg::ALU_SWAP: begin
                aluRes = {aluA[3:0], aluA[7:4]};
            end
            default: begin
                aluRes = aluA;
            end
        endcase
    end

    wire zNew = (aluRes == 8'h00);
    wire aluAffects = affZ | affNib | affC;

    // Bus address phase and data phase decode
    wire busAccept = hsel && htrans[1] && hready;
    wire inAct = (bus_reg == sfb_pkg::BUS_ACT);
    wire hitFlags = (addr_reg == sfb_pkg::OFS_CPU_FLAGS);
    wire hitBank = (addr_reg == sfb_pkg::OFS_BANK_SELECT);
    wire hitPtr = (addr_reg == sfb_pkg::OFS_POINTER);
    wire hitWin = (addr_reg == sfb_pkg::OFS_DATA_WINDOW);
    wire [12:0] ptrMap = mapPointer(ptr_reg);
    wire [12:0] coreMap = memIndirect ? mapPointer(ptr_reg) : mapBanked(bank_reg, memAddr);
    wire coreRam = memValid && coreMap[12];
    // The core owns the RAM in any cycle its request maps to RAM; the bus simply waits
    wire busRamWant = inAct && hitWin && ptrMap[12];
    wire busRamGo = busRamWant && !coreRam;
    wire actDone = inAct && !(busRamWant && coreRam);
    wire busWr = actDone && write_reg;
    wire ramEn = coreRam || busRamGo;
    wire ramWe = coreRam ? memWrite : write_reg;
    wire [11:0] ramAddr = coreRam ? coreMap[11:0] : ptrMap[11:0];
    wire [7:0] ramWdata = coreRam ? memWdata : hwdata[7:0];
    wire [7:0] ramRdata;

    sfb_ram #(
        .WIDTH(8),
        .DEPTH(sfb_pkg::RAM_DEPTH),
        .AW(sfb_pkg::RAM_AW)
    ) u_ram (
        .clk(clk),
        .en(ramEn),
        .we(ramWe),
        .addr(ramAddr),
        .wdata(ramWdata),
        .rdata(ramRdata)
    );

    // Register read mux, unmapped offsets read as zero
    logic [31:0] regRead;
    always_comb begin
        regRead = 32'h0000_0000;
        if (hitFlags) begin
            regRead = {24'h00_0000, flags_reg};
        end else if (hitBank) begin
            regRead = {27'h000_0000, bank_reg};
        end else if (hitPtr) begin
            regRead = {16'h0000, ptr_reg};
        end
    end

    // Bus slave sequencing
    always_comb begin
        bus_next = bus_reg;
        case (bus_reg)
            sfb_pkg::BUS_IDLE, sfb_pkg::BUS_DONE: begin
                bus_next = busAccept ? sfb_pkg::BUS_ACT : sfb_pkg::BUS_IDLE;
            end
            sfb_pkg::BUS_ACT: begin
                if (busRamGo && !write_reg) begin
                    bus_next = sfb_pkg::BUS_RDWAIT;
                end else if (actDone) begin
                    bus_next = sfb_pkg::BUS_DONE;
                end
            end
            sfb_pkg::BUS_RDWAIT: begin
                bus_next = sfb_pkg::BUS_DONE;
            end
            default: begin
                bus_next = sfb_pkg::BUS_IDLE;
            end
        endcase
    end

    // Flag register update; bits 7:5 are unimplemented and stay zero
    always_comb begin
        flags_next = flags_reg;
        if (busWr && hitFlags) begin
            flags_next[2:0] = hwdata[2:0];
        end
        if (aluValid && aluToStatus && !aluAffects) begin
            flags_next[2:0] = aluRes[2:0];
        end
        if (aluValid) begin
            // A status destination never overrides the flag logic
            if (affZ) begin
                flags_next[sfb_pkg::BIT_Z] = zNew;
            end
            if (affNib) begin
                flags_next[sfb_pkg::BIT_NIBBLE] = nibNew;
            end
            if (affC) begin
                flags_next[sfb_pkg::BIT_C] = cNew;
            end
        end
        flags_next[7:5] = 3'h0;
        if (wdtTimeoutEvent) begin
            flags_next[sfb_pkg::BIT_EXPIRY] = 1'b0;
        end
        if (sleepEvent) begin
            flags_next[sfb_pkg::BIT_EXPIRY] = 1'b1;
            flags_next[sfb_pkg::BIT_POWER_DOWN] = 1'b0;
        end
        if (porEvent || clrWdtEvent) begin
            flags_next[sfb_pkg::BIT_EXPIRY] = 1'b1;
            flags_next[sfb_pkg::BIT_POWER_DOWN] = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_reg <= sfb_pkg::FLAGS_RESET;
            bank_reg <= sfb_pkg::BANK_RESET;
            ptr_reg <= sfb_pkg::POINTER_RESET;
            bus_reg <= sfb_pkg::BUS_IDLE;
        end else begin
            flags_reg <= flags_next;
            bus_reg <= bus_next;
            if (busWr && hitBank) begin
                bank_reg <= hwdata[4:0];
            end
            if (busWr && hitPtr) begin
                ptr_reg <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_reg <= 8'h00;
            write_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            if (busAccept) begin
                addr_reg <= {haddr[7:2], 2'b00};
                write_reg <= hwrite;
            end
            if (actDone && !write_reg) begin
                rdata_reg <= regRead;
            end
            if (bus_reg == sfb_pkg::BUS_RDWAIT) begin
                rdata_reg <= {24'h00_0000, ramRdata};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aluRes_reg <= 8'h00;
            aluVal_reg <= 1'b0;
            memVal_reg <= 1'b0;
            memHit_reg <= 1'b0;
        end else begin
            aluVal_reg <= aluValid;
            if (aluValid) begin
                aluRes_reg <= aluRes;
            end
            memVal_reg <= memValid && !memWrite;
            memHit_reg <= coreRam;
        end
    end

    // Outputs
    assign hreadyout = (bus_reg == sfb_pkg::BUS_IDLE) || (bus_reg == sfb_pkg::BUS_DONE);
    assign hrdata = rdata_reg;
    assign hresp = 1'b0;
    assign aluResult = aluRes_reg;
    assign aluResultValid = aluVal_reg;
    // Core and SFR offsets are not held here and read as zero
    assign memRdata = memHit_reg ? ramRdata : 8'h00;
    assign memRdataValid = memVal_reg;
    assign cpuFlags = flags_reg;
    assign bankSelect = bank_reg;
    assign pointerValue = ptr_reg;
endmodule
`default_nettype wire

// ---- verilog/sfb_ram.sv ----
// Single port byte memory with registered read data
`default_nettype none
module sfb_ram #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2576,
    parameter int AW = 12
) (
    // Clock
    input wire logic clk,
    // Access port
    input wire logic en,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (en && we) begin
            mem[addr] <= wdata;
        end
        if (en && !we) begin
            rdata <= mem[addr];
        end
    end
endmodule
`default_nettype wire
